/* File: core/fsc_pkg.sv */
// How it works
// - filter runs from base offset over taps
// - one base-offset write selects filter
// - output scaled by 2^(7-scale), rounded
// - scale ignored for wide serial words
// - master drives sync pulses on edge
// - slave samples external sync pulses
// - filter sync edge realigns all decimation phases, comb sync stages 1 and 2
// - comb sync every m1*m2 cycles
// - filter sync coincides, every mf comb
// - sync pads bidirectional, tristated as slave
// - master listens to its own pads
// - counters free run without sync
// - both ports reach all; serial wins
// - micro ready withheld during serial access
// - reset sets soft-reset bit 0
// - reset clears sync-role bit 3
// - mode bits 1,2 select input modes
// - oscillator control bypass and dither bits
// - mask write shadow, read active
// - scale register field layout
// - decimation and taps hold value minus one
// - mode bits 0-2 low means single real
// - sample history not cleared by reset
package fsc_pkg;
  localparam logic [9:0] ADDR_COEF_BASE = 10'h000;
  localparam logic [9:0] ADDR_HIST_BASE = 10'h100;
  localparam logic [9:0] ADDR_MODE      = 10'h300;
  localparam logic [9:0] ADDR_OSC_CTRL  = 10'h301;
  localparam logic [9:0] ADDR_SYNC_MASK = 10'h302;
  localparam logic [9:0] ADDR_TUNING    = 10'h303;
  localparam logic [9:0] ADDR_PHASE     = 10'h304;
  localparam logic [9:0] ADDR_IN_SCALE  = 10'h305;
  localparam logic [9:0] ADDR_DEC1      = 10'h306;
  localparam logic [9:0] ADDR_SCALE2    = 10'h307;
  localparam logic [9:0] ADDR_DEC2      = 10'h308;
  localparam logic [9:0] ADDR_OUT_SCALE = 10'h309;
  localparam logic [9:0] ADDR_DECF      = 10'h30A;
  localparam logic [9:0] ADDR_COEF_OFF  = 10'h30B;
  localparam logic [9:0] ADDR_TAPS      = 10'h30C;
  localparam logic [9:0] ADDR_RSVD      = 10'h30D;
  localparam logic [7:0] MODE_RESET_VAL = 8'h01;
  localparam int MODE_SOFT_RESET  = 0;
  localparam int MODE_DUAL_REAL   = 1;
  localparam int MODE_CPLX        = 2;
  localparam int MODE_SYNC_MASTER = 3;
  localparam logic [3:0] MODE_USED_MASK   = 4'hF;
  localparam logic [2:0] OSC_USED_MASK    = 3'h7;
  localparam logic [7:0] IN_SCALE_MASK    = 8'hF7;
  localparam logic [4:0] SCALE2_MASK      = 5'h1F;
  localparam logic [2:0] OUT_SCALE_MASK   = 3'h7;
  localparam logic [3:0] OUT_SCALE_TOP    = 4'h7;
  localparam int COEF_W  = 20;
  localparam int HIST_W  = 36;
  localparam int FULL_W  = 23;
  localparam int WORD_W  = 16;
  localparam int DEPTH   = 256;

  typedef enum logic [1:0] {
    PORT_IDLE   = 2'b00,
    PORT_SERIAL = 2'b01,
    PORT_MICRO  = 2'b10
  } fsc_owner_t;

  typedef enum logic [1:0] {
    WL_16 = 2'b00,
    WL_24 = 2'b01,
    WL_32 = 2'b10
  } fsc_wlen_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [9:0]  addr;
    logic [35:0] wdata;
  } fsc_acc_t;

  typedef struct packed {
    logic [7:0] dec1_m1;
    logic [7:0] dec2_m1;
    logic [7:0] decf_m1;
  } fsc_dec_t;
endpackage

/* File: core/fsc_core.sv */
`timescale 1ns/10ps
module fsc_core
  import fsc_pkg::*;
(
  input  wire logic                i_core_clk,
  input  wire logic                i_nrst,
  // microprocessor side: request held until o_mp_ready
  input  wire fsc_acc_t            i_mp_acc,
  output logic                     o_mp_ready,
  output logic [HIST_W-1:0]        o_mp_rdata,
  // serial side: request held until o_sp_done
  input  wire fsc_acc_t            i_sp_acc,
  output logic                     o_sp_done,
  output logic [HIST_W-1:0]        o_sp_rdata,
  // filter engine hooks
  input  wire logic [7:0]          i_tap_index,
  output logic [COEF_W-1:0]        o_coef,
  input  wire logic signed [FULL_W-1:0] i_full_result,
  input  wire fsc_wlen_t           i_word_len,
  output logic [WORD_W-1:0]        o_port_word,
  // sync pads: comb stage, final filter, oscillator
  input  wire logic [2:0]          i_sync_pad,
  output logic [2:0]               o_sync_pad,
  output logic [2:0]               o_sync_pad_oe,
  // configuration out to the datapath
  output logic                     o_soft_reset,
  output logic                     o_dual_real,
  output logic                     o_cplx,
  output logic                     o_single_real,
  output logic [2:0]               o_osc_ctrl,
  output logic [31:0]              o_tuning_word,
  output logic [15:0]              o_phase_offset,
  output logic [7:0]               o_in_scale,
  output logic [4:0]               o_second_stage_scale,
  output fsc_dec_t                 o_dec,
  output logic [7:0]               o_tap_count_m1,
  output logic                     o_stage1_tick,
  output logic                     o_stage2_tick,
  output logic                     o_final_tick
);

  logic [COEF_W-1:0] coef_mem [DEPTH];
  logic [HIST_W-1:0] hist_mem [DEPTH];

  logic [7:0]  mode_reg;
  logic [2:0]  osc_reg;
  logic [31:0] mask_shadow_reg;
  logic [31:0] mask_active_reg;
  logic [31:0] tuning_reg;
  logic [15:0] phase_reg;
  logic [7:0]  in_scale_reg;
  logic [7:0]  dec1_reg;
  logic [4:0]  scale2_reg;
  logic [7:0]  dec2_reg;
  logic [2:0]  out_scale_reg;
  logic [7:0]  decf_reg;
  logic [7:0]  coef_off_reg;
  logic [7:0]  taps_reg;
  fsc_owner_t  owner_reg;
  fsc_owner_t  owner_next;

  // arbitration: serial first unless micro already owns the bus
  always_comb begin
    owner_next = owner_reg;
    case (owner_reg)
      PORT_IDLE: begin
        if (i_sp_acc.req) begin
          owner_next = PORT_SERIAL;
        end else if (i_mp_acc.req) begin
          owner_next = PORT_MICRO;
        end
      end
      PORT_SERIAL: owner_next = PORT_IDLE;
      PORT_MICRO:  owner_next = PORT_IDLE;
      default:     owner_next = PORT_IDLE;
    endcase
  end

  wire      sp_go = (owner_reg == PORT_SERIAL);
  wire      mp_go = (owner_reg == PORT_MICRO);
  fsc_acc_t acc;
  assign acc = sp_go ? i_sp_acc : i_mp_acc;
  wire      do_acc = sp_go | mp_go;
  wire      do_wr  = do_acc & acc.wr;
  wire      in_coef = (acc.addr[9:8] == ADDR_COEF_BASE[9:8]);
  wire      in_hist = (acc.addr[9:8] == ADDR_HIST_BASE[9:8]);

  // micro stalls whenever serial owns the bus
  assign o_mp_ready = mp_go;
  assign o_sp_done  = sp_go;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
    hit = (a == r);
  endfunction

  logic [HIST_W-1:0] rd_val;
  always_comb begin
    rd_val = '0;
    if (in_coef) begin
      rd_val = {{(HIST_W-COEF_W){1'b0}}, coef_mem[acc.addr[7:0]]};
    end else if (in_hist) begin
      rd_val = hist_mem[acc.addr[7:0]];
    end else begin
      case (acc.addr)
        ADDR_MODE:      rd_val = {28'h0, mode_reg};
        ADDR_OSC_CTRL:  rd_val = {33'h0, osc_reg};
        ADDR_SYNC_MASK: rd_val = {4'h0, mask_active_reg};
        ADDR_TUNING:    rd_val = {4'h0, tuning_reg};
        ADDR_PHASE:     rd_val = {20'h0, phase_reg};
        ADDR_IN_SCALE:  rd_val = {28'h0, in_scale_reg};
        ADDR_DEC1:      rd_val = {28'h0, dec1_reg};
        ADDR_SCALE2:    rd_val = {31'h0, scale2_reg};
        ADDR_DEC2:      rd_val = {28'h0, dec2_reg};
        ADDR_OUT_SCALE: rd_val = {33'h0, out_scale_reg};
        ADDR_DECF:      rd_val = {28'h0, decf_reg};
        ADDR_COEF_OFF:  rd_val = {28'h0, coef_off_reg};
        ADDR_TAPS:      rd_val = {28'h0, taps_reg};
        default:        rd_val = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      owner_reg <= PORT_IDLE;
      o_mp_rdata <= '0;
      o_sp_rdata <= '0;
    end else begin
      owner_reg <= owner_next;
      if (mp_go) begin
        o_mp_rdata <= rd_val;
      end
      if (sp_go) begin
        o_sp_rdata <= rd_val;
      end
    end
  end

  // memories have no reset: history must be flushed by software
  always_ff @(posedge i_core_clk) begin
    if (do_wr && in_coef) begin
      coef_mem[acc.addr[7:0]] <= acc.wdata[COEF_W-1:0];
    end
    if (do_wr && in_hist) begin
      hist_mem[acc.addr[7:0]] <= acc.wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_reg        <= MODE_RESET_VAL;
      osc_reg         <= '0;
      mask_shadow_reg <= '0;
      tuning_reg      <= '0;
      phase_reg       <= '0;
      in_scale_reg    <= '0;
      dec1_reg        <= '0;
      scale2_reg      <= '0;
      dec2_reg        <= '0;
      out_scale_reg   <= '0;
      decf_reg        <= '0;
      coef_off_reg    <= '0;
      taps_reg        <= '0;
    end else if (do_wr) begin
      if (hit(acc.addr, ADDR_MODE))      mode_reg <= {4'h0, acc.wdata[3:0] & MODE_USED_MASK};
      if (hit(acc.addr, ADDR_OSC_CTRL))  osc_reg <= acc.wdata[2:0] & OSC_USED_MASK;
      if (hit(acc.addr, ADDR_SYNC_MASK)) mask_shadow_reg <= acc.wdata[31:0];
      if (hit(acc.addr, ADDR_TUNING))    tuning_reg <= acc.wdata[31:0];
      if (hit(acc.addr, ADDR_PHASE))     phase_reg <= acc.wdata[15:0];
      if (hit(acc.addr, ADDR_IN_SCALE))  in_scale_reg <= acc.wdata[7:0] & IN_SCALE_MASK;
      if (hit(acc.addr, ADDR_DEC1))      dec1_reg <= acc.wdata[7:0];
      if (hit(acc.addr, ADDR_SCALE2))    scale2_reg <= acc.wdata[4:0] & SCALE2_MASK;
      if (hit(acc.addr, ADDR_DEC2))      dec2_reg <= acc.wdata[7:0];
      if (hit(acc.addr, ADDR_OUT_SCALE)) out_scale_reg <= acc.wdata[2:0] & OUT_SCALE_MASK;
      if (hit(acc.addr, ADDR_DECF))      decf_reg <= acc.wdata[7:0];
      if (hit(acc.addr, ADDR_COEF_OFF))  coef_off_reg <= acc.wdata[7:0];
      if (hit(acc.addr, ADDR_TAPS))      taps_reg <= acc.wdata[7:0];
    end
  end

  // mode decode
  wire master = mode_reg[MODE_SYNC_MASTER];
  assign o_soft_reset   = mode_reg[MODE_SOFT_RESET];
  assign o_dual_real    = mode_reg[MODE_DUAL_REAL];
  assign o_cplx         = mode_reg[MODE_CPLX];
  assign o_single_real  = ~(mode_reg[MODE_SOFT_RESET] | mode_reg[MODE_DUAL_REAL]
                            | mode_reg[MODE_CPLX]);
  assign o_osc_ctrl           = osc_reg;
  assign o_tuning_word        = tuning_reg;
  assign o_phase_offset       = phase_reg;
  assign o_in_scale           = in_scale_reg;
  assign o_second_stage_scale = scale2_reg;
  assign o_dec                = '{dec1_m1: dec1_reg, dec2_m1: dec2_reg, decf_m1: decf_reg};
  assign o_tap_count_m1       = taps_reg;

  // coefficient fetch relative to the base offset, wraps in 8 bits
  logic [7:0] coef_addr;
  assign coef_addr = 8'(coef_off_reg + i_tap_index);
  always_ff @(posedge i_core_clk) begin
    o_coef <= coef_mem[coef_addr];
  end

  // output word: shift left by 7-scale then round to 16 bits
  logic [3:0]         shamt;
  logic signed [30:0] scaled;
  logic signed [30:0] rounded;
  assign shamt   = OUT_SCALE_TOP - {1'b0, out_scale_reg};
  assign scaled  = 31'(i_full_result) <<< shamt;
  assign rounded = scaled + 31'sh40;
  wire [WORD_W-1:0] narrow = rounded[FULL_W-1:FULL_W-WORD_W];
  wire [WORD_W-1:0] wide   = i_full_result[FULL_W-1:FULL_W-WORD_W];
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_port_word <= '0;
    end else begin
      o_port_word <= (i_word_len == WL_16) ? narrow : wide;
    end
  end

  // sync pads: two-flop synchronisers on the pad inputs
  logic [2:0] pad_s1_reg;
  logic [2:0] pad_s2_reg;
  logic [2:0] pad_s3_reg;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pad_s1_reg <= '0;
      pad_s2_reg <= '0;
      pad_s3_reg <= '0;
    end else begin
      pad_s1_reg <= i_sync_pad;
      pad_s2_reg <= pad_s1_reg;
      pad_s3_reg <= pad_s2_reg;
    end
  end
  wire [2:0] sync_rise = pad_s2_reg & ~pad_s3_reg;

  // active mask loads from shadow on an oscillator sync edge
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mask_active_reg <= '0;
    end else if (sync_rise[2]) begin
      mask_active_reg <= mask_shadow_reg;
    end
  end

  // decimation phase counters, free running
  logic [7:0] cnt1_reg;
  logic [7:0] cnt2_reg;
  logic [7:0] cntf_reg;
  wire wrap1 = (cnt1_reg >= dec1_reg);
  wire wrap2 = wrap1 & (cnt2_reg >= dec2_reg);
  wire wrapf = wrap2 & (cntf_reg >= decf_reg);
  wire realign_comb = sync_rise[0] | sync_rise[1];

  // one step of the nested decimation counters, packed as {stage1, stage2, final}
  function automatic logic [23:0] advance(input logic [23:0] s, input fsc_dec_t d);
    logic w1;
    logic w2;
    logic wf;
    w1 = (s[23:16] >= d.dec1_m1);
    w2 = w1 & (s[15:8] >= d.dec2_m1);
    wf = w2 & (s[7:0] >= d.decf_m1);
    advance = s;
    advance[23:16] = w1 ? 8'h00 : 8'(s[23:16] + 8'h01);
    if (w1) begin
      advance[15:8] = w2 ? 8'h00 : 8'(s[15:8] + 8'h01);
    end
    if (w2) begin
      advance[7:0] = wf ? 8'h00 : 8'(s[7:0] + 8'h01);
    end
  endfunction

  // a sync edge is seen three cycles after the wrap that launched it (pulse flop plus
  // two synchroniser flops), so the counters load the phase they would reach by then;
  // a master hearing its own pulse is left exactly where it already was
  wire [23:0] cnt_now  = {cnt1_reg, cnt2_reg, cntf_reg};
  wire [23:0] cnt_free = advance(cnt_now, o_dec);
  wire [23:0] cnt_sync = advance(advance(advance(24'h0, o_dec), o_dec), o_dec);
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt1_reg <= '0;
      cnt2_reg <= '0;
      cntf_reg <= '0;
    end else begin
      {cnt1_reg, cnt2_reg} <= realign_comb ? cnt_sync[23:8] : cnt_free[23:8];
      cntf_reg <= sync_rise[1] ? cnt_sync[7:0] : cnt_free[7:0];
    end
  end
  assign o_stage1_tick = wrap1;
  assign o_stage2_tick = wrap2;
  assign o_final_tick  = wrapf;

  // master pulses: comb every m1*m2, filter on coincident comb
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sync_pad <= '0;
    end else begin
      o_sync_pad <= {wrap2 & (mask_shadow_reg == mask_active_reg), wrapf, wrap2};
    end
  end
  assign o_sync_pad_oe = {3{master}};
endmodule

/* File: testbench/fsc_core_properties.sv */
`timescale 1ns/10ps
module fsc_core_properties
  import fsc_pkg::*;
(
  input wire logic       i_core_clk,
  input wire logic       i_nrst,
  input wire fsc_acc_t   i_mp_acc,
  input wire logic       o_mp_ready,
  input wire logic       o_sp_done,
  input wire logic [2:0] o_sync_pad,
  input wire logic [2:0] o_sync_pad_oe,
  input wire logic       o_soft_reset,
  input wire logic       o_dual_real,
  input wire logic       o_cplx,
  input wire logic       o_single_real,
  input wire fsc_dec_t   o_dec,
  input wire logic       o_stage1_tick,
  input wire logic       o_stage2_tick,
  input wire logic       o_final_tick
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  property p_reset_mode;
    $rose(i_nrst) |-> o_soft_reset && o_sync_pad_oe == 3'h0;
  endproperty
  property p_mp_pulse;
    o_mp_ready |=> !o_mp_ready;
  endproperty
  property p_sp_pulse;
    o_sp_done |=> !o_sp_done;
  endproperty
  property p_serial_excl;
    o_sp_done |-> !o_mp_ready;
  endproperty
  // a stalled micro access must still finish once the serial one is out of the way
  property p_mp_answered;
    $rose(i_mp_acc.req) |-> ##[1:12] o_mp_ready;
  endproperty
  property p_oe_uniform;
    o_sync_pad_oe == 3'h0 || o_sync_pad_oe == 3'h7;
  endproperty
  property p_oe_by_write;
    !$stable(o_sync_pad_oe) |-> $past(o_mp_ready || o_sp_done);
  endproperty
  property p_mode_decode;
    o_single_real == (!o_soft_reset && !o_dual_real && !o_cplx);
  endproperty
  property p_tick_nest;
    o_final_tick |-> o_stage2_tick && o_stage1_tick;
  endproperty
  property p_final_with_comb;
    o_sync_pad_oe[1] && o_sync_pad[1] |-> o_sync_pad[0];
  endproperty
  property p_comb_period;
    o_sync_pad_oe[0] && o_sync_pad[0] && o_dec.dec1_m1 == 8'h01 && o_dec.dec2_m1 == 8'h01
      |=> !o_sync_pad[0] [*3] ##1 o_sync_pad[0];
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode not at reset state");
  a_mp_pulse: assert property (p_mp_pulse) else $error("micro ready too long");
  a_sp_pulse: assert property (p_sp_pulse) else $error("serial done too long");
  a_serial_excl: assert property (p_serial_excl) else $error("both ports served");
  a_mp_answered: assert property (p_mp_answered) else $error("micro access starved");
  a_oe_uniform: assert property (p_oe_uniform) else $error("pad enables split");
  a_oe_by_write: assert property (p_oe_by_write) else $error("role changed unasked");
  a_mode_decode: assert property (p_mode_decode) else $error("input mode decode wrong");
  a_tick_nest: assert property (p_tick_nest) else $error("stage ticks not nested");
  a_final_with_comb: assert property (p_final_with_comb) else $error("lone filter sync");
  a_comb_period: assert property (p_comb_period) else $error("comb sync period wrong");
  c_stall: cover property (o_mp_ready && $past(o_sp_done, 2));
  c_master_final: cover property (o_sync_pad_oe[1] && o_sync_pad[1]);
  c_final_tick: cover property (o_final_tick);
endmodule

bind fsc_core fsc_core_properties i_fsc_core_properties (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_mp_acc(i_mp_acc), .o_mp_ready(o_mp_ready),
  .o_sp_done(o_sp_done), .o_sync_pad(o_sync_pad), .o_sync_pad_oe(o_sync_pad_oe),
  .o_soft_reset(o_soft_reset), .o_dual_real(o_dual_real), .o_cplx(o_cplx),
  .o_single_real(o_single_real), .o_dec(o_dec), .o_stage1_tick(o_stage1_tick),
  .o_stage2_tick(o_stage2_tick), .o_final_tick(o_final_tick));

/* File: testbench/fsc_peer.sv */
`timescale 1ns/10ps
// peer receiver chip: acts as sync master only while this device listens
module fsc_peer (
  input  wire logic [2:0] i_fire,
  input  wire logic [2:0] i_dut_pad,
  input  wire logic [2:0] i_dut_oe,
  output logic [2:0]      o_pad
);
  // pad level resolved from both drivers; the peer drives low between its pulses
  assign o_pad = (i_dut_oe & i_dut_pad) | (~i_dut_oe & i_fire);
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import fsc_pkg::*;
;
  logic clk = 0, nrst = 0;
  fsc_acc_t mp_acc = '0, sp_acc = '0;
  logic [7:0] tap = 8'h00;
  logic signed [22:0] full = '0;
  fsc_wlen_t wlen = WL_16;
  logic [2:0] fire = 3'h0, pad, dpad, doe;
  logic [2:0] md, osc;
  logic [31:0] tw;
  logic [7:0] ntap, isc;
  logic [4:0] sc2;
  logic mrdy, sdone, t1, t2, tf, srst;
  logic [35:0] mq, sq, q;
  logic [19:0] coef;
  logic [15:0] pw;
  fsc_dec_t dec;
  int n_errors = 0, comparisons = 0, k, k2;
  always #10 clk = ~clk;
  fsc_core i_fsc_core (.i_core_clk(clk), .i_nrst(nrst), .i_mp_acc(mp_acc), .o_mp_ready(mrdy),
    .o_mp_rdata(mq), .i_sp_acc(sp_acc), .o_sp_done(sdone), .o_sp_rdata(sq), .i_tap_index(tap),
    .o_coef(coef), .i_full_result(full), .i_word_len(wlen), .o_port_word(pw),
    .i_sync_pad(pad), .o_sync_pad(dpad), .o_sync_pad_oe(doe), .o_soft_reset(srst),
    .o_dual_real(md[2]), .o_cplx(md[1]), .o_single_real(md[0]), .o_osc_ctrl(osc),
    .o_tuning_word(tw), .o_phase_offset(), .o_in_scale(isc), .o_second_stage_scale(sc2),
    .o_dec(dec), .o_tap_count_m1(ntap), .o_stage1_tick(t1), .o_stage2_tick(t2),
    .o_final_tick(tf));
  fsc_peer i_fsc_peer (.i_fire(fire), .i_dut_pad(dpad), .i_dut_oe(doe), .o_pad(pad));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic acc(input bit sp, input logic wr, input logic [9:0] a, input logic [35:0] d,
                     output logic [35:0] r);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    if (sp) sp_acc = '{1'b1, wr, a, d};
    else mp_acc = '{1'b1, wr, a, d};
    while ((sp ? sdone : mrdy) !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) begin
      n_errors++;
      summarize();
    end
    @(posedge clk);
    #1;
    if (sp) sp_acc = '0;
    else mp_acc = '0;
    @(negedge clk);
    r = sp ? sq : mq;
  endtask
  task automatic rst();
    @(posedge clk);
    #1 nrst = 0;
    repeat (2) @(posedge clk);
    #1 nrst = 1;
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    #1 fire[b] = 1'b1;
    @(posedge clk);
    #1 fire[b] = 1'b0;
  endtask
  task automatic t_history();
    chk({srst, doe, md}, 7'h40);
    acc(0, 0, ADDR_MODE, 36'h0, q);
    chk(q, 36'h01);
    acc(1, 1, ADDR_MODE, 36'h0, q);
    chk(md, 3'h1);
    acc(1, 1, ADDR_HIST_BASE + 10'h005, 36'h9_8765_4321, q);
    rst();
    chk({srst, doe, md}, 7'h40);
    acc(0, 0, ADDR_HIST_BASE + 10'h005, 36'h0, q);
    chk(q, 36'h9_8765_4321);
    $display("test history done");
  endtask
  task automatic t_regs();
    logic [9:0] a[11] = '{ADDR_MODE, ADDR_MODE, ADDR_MODE, ADDR_OSC_CTRL, ADDR_IN_SCALE,
      ADDR_SCALE2, ADDR_OUT_SCALE, ADDR_TAPS, ADDR_RSVD, 10'h250, ADDR_TUNING};
    logic [35:0] w[11] = '{36'h02, 36'h04, 36'h00, 36'h07, 36'hF7, 36'h1F, 36'h07, 36'h03,
      36'h00, 36'h55, 36'hFFFF_FFFF};
    logic [35:0] e[11] = '{36'h02, 36'h04, 36'h00, 36'h07, 36'hF7, 36'h1F, 36'h07, 36'h03,
      36'h00, 36'h00, 36'hFFFF_FFFF};
    for (int i = 0; i < 11; i++) begin
      acc(i[0], 1, a[i], w[i], q);
      acc(!i[0], 0, a[i], 36'h0, q);
      chk(q, e[i]);
      if (i < 3) chk(md, i == 0 ? 3'h4 : (i == 1 ? 3'h2 : 3'h1));
    end
    chk({osc, sc2}, 8'hFF);
    chk({ntap, isc}, 16'h03F7);
    chk(tw, 32'hFFFF_FFFF);
    $display("test registers done");
  endtask
  task automatic t_arb();
    time ts, tm;
    fork
      begin acc(1, 1, ADDR_DEC1, 36'h01, q); ts = $time; end
      begin acc(0, 1, ADDR_DEC2, 36'h01, q); tm = $time; end
    join
    chk(ts < tm, 1);
    chk(dec, 24'h01_01_00);
    $display("test arbitration done");
  endtask
  task automatic t_coef();
    for (int i = 0; i < 4; i++) begin
      acc(0, 1, ADDR_COEF_BASE + 10'h10 + i, 36'hA0000 + i, q);
      acc(1, 1, ADDR_COEF_BASE + 10'h20 + i, 36'h50000 + i, q);
    end
    @(posedge clk);
    #1 tap = 8'h02;
    acc(0, 1, ADDR_COEF_OFF, 36'h10, q);
    repeat (2) @(negedge clk);
    chk(coef, 20'hA0002);
    acc(1, 1, ADDR_COEF_OFF, 36'h20, q);
    repeat (2) @(negedge clk);
    chk(coef, 20'h50002);
    $display("test coefficients done");
  endtask
  task automatic t_round();
    logic signed [30:0] v;
    @(posedge clk);
    #1 full = 23'sh12345;
    for (int s = 0; s < 10; s++) begin
      @(posedge clk);
      #1 wlen = s > 7 ? (s == 8 ? WL_24 : WL_32) : WL_16;
      acc(0, 1, ADDR_OUT_SCALE, 36'(s % 8), q);
      repeat (2) @(negedge clk);
      v = (31'(full) <<< (7 - s % 8)) + 31'sd64;
      chk(pw, s > 7 ? full[22:7] : v[22:7]);
    end
    $display("test rounding done");
  endtask
  task automatic t_mask();
    acc(1, 1, ADDR_SYNC_MASK, 36'h1234_5678, q);
    acc(0, 0, ADDR_SYNC_MASK, 36'h0, q);
    chk(q, 36'h0);
    pulse(2);
    repeat (6) @(posedge clk);
    acc(1, 0, ADDR_SYNC_MASK, 36'h0, q);
    chk(q, 36'h1234_5678);
    $display("test mask done");
  endtask
  task automatic meas(input int b, input int gap, output int n);
    repeat (gap) @(posedge clk);
    pulse(b);
    repeat (4) @(posedge clk);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((b == 0 ? t2 : tf) !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_errors++;
      summarize();
    end
  endtask
  task automatic t_slave();
    acc(0, 1, ADDR_DECF, 36'h02, q);
    chk(doe, 3'h0);
    for (int b = 0; b < 2; b++) begin
      meas(b, 1, k);
      meas(b, 2, k2);
      chk(k2, k);
    end
    $display("test slave sync done");
  endtask
  task automatic waitp(input int b, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (dpad[b] !== 1'b1 && n < 60);
    if (n >= 60) begin
      n_errors++;
      summarize();
    end
  endtask
  task automatic t_master();
    acc(1, 1, ADDR_MODE, 36'h08, q);
    chk(doe, 3'h7);
    waitp(0, k);
    waitp(0, k);
    chk(k, 4);
    waitp(1, k);
    waitp(1, k);
    chk(k, 12);
    $display("test master sync done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 nrst = 1;
    t_history();
    t_regs();
    t_arb();
    t_coef();
    t_round();
    t_mask();
    t_slave();
    t_master();
    summarize();
  end
endmodule
